// >>> hdl/ebda_pkg.sv
// Constants and types shared by the external bus decode and abort logic
package ebda_pkg;
	localparam int          NUM_CS        = 8;
	localparam int          EXT_ADDR_W    = 24;
	localparam int          DATA_W        = 16;
	localparam int          BASE_W        = 12;
	localparam logic [31:0] REG_BASE      = 32'hffe00000;
	localparam logic [31:0] REG_SIZE      = 32'h00004000;
	localparam logic [31:0] VEC_PREFETCH  = 32'h0000000c;
	localparam logic [31:0] VEC_DATA      = 32'h00000010;
	localparam logic [1:0]  SIZE_BYTE     = 2'h0;
	localparam logic [1:0]  SIZE_HALF     = 2'h1;
	localparam logic [1:0]  SIZE_WORD     = 2'h2;
	localparam logic [1:0]  TYPE_READ     = 2'h0;
	localparam logic [1:0]  TYPE_WRITE    = 2'h1;
	localparam logic [1:0]  TYPE_FETCH    = 2'h2;
	localparam int          ST_UNDEF_POS  = 0;
	localparam int          ST_MISAL_POS  = 1;
	localparam int          ST_PROT_POS   = 2;
	localparam int          ST_SIZE_POS   = 8;
	localparam int          ST_TYPE_POS   = 10;
	localparam int          ST_W          = 16;
	localparam logic [31:0] ABORT_ADDR_RST = 32'h00000000;
	localparam logic [15:0] ABORT_STAT_RST = 16'h0000;
	localparam logic [2:0]  ALE_RST       = 3'h0;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_LEAD   = 2'b01,
		ST_STROBE = 2'b11
	} ebda_state_t;
endpackage

// >>> hdl/ebda_abort_rec.sv
// Abort address and status record
`timescale 1ns/100ps
module ebda_abort_rec (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic        capture,
	input  wire logic [31:0] fault_addr,
	input  wire logic [15:0] fault_status,
	output logic      [31:0] abort_address_reg,
	output logic      [15:0] abort_status_reg
);
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] stat;
	} ebda_rec_t;

	ebda_rec_t rec_q;
	ebda_rec_t rec_d;

	always_comb begin
		rec_d = rec_q;
		if (capture) begin
			rec_d.addr = fault_addr;
			rec_d.stat = fault_status;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rec_q.addr <= ebda_pkg::ABORT_ADDR_RST;
			rec_q.stat <= ebda_pkg::ABORT_STAT_RST;
		end else if (clk_en) begin
			rec_q <= rec_d;
		end
	end

	assign abort_address_reg = rec_q.addr;
	assign abort_status_reg  = rec_q.stat;
endmodule // ebda_abort_rec

// >>> hdl/ebda_top.sv
// External bus front end: decode, chip selects, strobes and aborts
//
// Function
// - 24-bit address, eight selects, upper lines shared
// - 16-bit data bus for 8/16-bit devices
// - 8-bit uses A0-A23, 16-bit ignores A0
// - Base and page decode, image repeats
// - Unmapped address gives prefetch or data abort
// - Overlap asserts all, lowest select configures
// - Abort overwrites address record, last kept
// - Reset clears abort address and status
// - Status holds undefined, misaligned, size, type
// - Internal access: address held, pins quiet
// - Selects 0-3 low, 4-7 high active
// - Four to eight active chip selects
// - Separate strobes, single-cycle access possible
// - Protected register region needs privileged mode
// - Control field picks shared lines, default none
// - Per-select 8 or 16-bit width
// - Per-select byte-write or byte-select scheme
// - Standard read until early read chosen
`timescale 1ns/100ps
module ebda_top #(
	parameter int NCS = ebda_pkg::NUM_CS
) (
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  clk_en,
	input  wire logic                  req_valid,
	output logic                       req_ready,
	input  wire logic [31:0]           req_addr,
	input  wire logic                  req_write,
	input  wire logic                  req_fetch,
	input  wire logic [1:0]            req_size,
	input  wire logic                  req_user,
	input  wire logic                  req_internal,
	input  wire logic [31:0]           req_wdata,
	output logic      [31:0]           rd_data,
	output logic                       rd_valid,
	input  wire logic [NCS-1:0]        cs_enable,
	input  wire logic [NCS-1:0][11:0]  cs_base,
	input  wire logic [NCS-1:0][1:0]   cs_page,
	input  wire logic [NCS-1:0]        data_width_field,
	input  wire logic [NCS-1:0]        byte_access_type_field,
	input  wire logic [2:0]            mcr_ale,
	input  wire logic                  mcr_early_read,
	input  wire logic                  protection_mode_input,
	output logic      [23:0]           ext_addr,
	output logic      [3:0]            low_active_selects_n,
	output logic                       read_strobe_n,
	output logic      [1:0]            byte_write_strobes_n,
	output logic      [15:0]           data_o,
	output logic                       data_oe,
	input  wire logic [15:0]           data_i,
	input  wire logic                  wait_request_n,
	output logic                       abort_prefetch,
	output logic                       abort_data,
	output logic      [31:0]           abort_address_reg,
	output logic      [15:0]           abort_status_reg
);
	typedef struct packed {
		ebda_pkg::ebda_state_t st;
		logic [31:0]           addr;
		logic [1:0]            beats;
		logic [7:0]            hit;
		logic                  wide;
		logic                  bsel;
		logic                  wr;
		logic [1:0]            size;
		logic [15:0]           dout;
		logic                  doe;
		logic [31:0]           rd;
		logic                  rd_valid;
		logic                  last_wr;
		logic                  ab_pre;
		logic                  ab_dat;
		logic [23:0]           pin_addr;
	} ebda_regs_t;

	ebda_regs_t q;
	ebda_regs_t d;
	logic [7:0]  hits;
	logic [2:0]  sel;
	logic        misal;
	logic        in_reg;
	logic        prot_bad;
	logic        abort_ev;
	logic [15:0] fault_status;
	logic        busy;
	logic        strobe;
	logic        lane_lo;
	logic        lane_hi;

	// Page match on the upper bits, low base bits masked by page size
	function automatic logic cs_match(input logic [31:0] a, input logic [11:0] base,
		input logic [1:0] page);
		logic [11:0] mask;
		mask = 12'hfff << (2 * page);
		return ((a[31:20] & mask) == (base & mask));
	endfunction

	// Remaining beats minus one for a size on a bus width
	function automatic logic [1:0] beats_of(input logic [1:0] size, input logic wide);
		logic [1:0] b;
		b = 2'h0;
		if (size == ebda_pkg::SIZE_HALF)
			b = wide ? 2'h0 : 2'h1;
		else if (size == ebda_pkg::SIZE_WORD)
			b = wide ? 2'h1 : 2'h3;
		return b;
	endfunction

	// Write data placed on the external lanes
	function automatic logic [15:0] lane_data(input logic [31:0] w, input logic [1:0] off,
		input logic [1:0] size, input logic wide);
		logic [7:0]  b;
		logic [15:0] h;
		b = w[8*off +: 8];
		h = w[16*off[1] +: 16];
		if (!wide)
			return {8'h00, b};
		return (size == ebda_pkg::SIZE_BYTE) ? {b, b} : h;
	endfunction

	always_comb begin
		hits = 8'h00;
		for (int i = 0; i < NCS; i++) begin
			if (cs_enable[i] && cs_match(req_addr, cs_base[i], cs_page[i]))
				hits[i] = (i < 4) || (mcr_ale > 3'(i - 4));
		end
		sel = 3'h0;
		for (int i = NCS - 1; i >= 0; i--) begin
			if (hits[i])
				sel = 3'(i);
		end
	end

	assign misal = ((req_size == ebda_pkg::SIZE_HALF) && req_addr[0]) ||
		((req_size == ebda_pkg::SIZE_WORD) && (req_addr[1:0] != 2'h0));
	assign in_reg = (req_addr >= ebda_pkg::REG_BASE) &&
		(req_addr < ebda_pkg::REG_BASE + ebda_pkg::REG_SIZE);
	assign prot_bad = in_reg && protection_mode_input && req_user;

	always_comb begin
		fault_status = 16'h0000;
		fault_status[ebda_pkg::ST_UNDEF_POS] = !prot_bad && (hits == 8'h00);
		fault_status[ebda_pkg::ST_MISAL_POS] = !prot_bad && misal;
		fault_status[ebda_pkg::ST_PROT_POS] = prot_bad;
		fault_status[ebda_pkg::ST_SIZE_POS +: 2] = req_size;
		fault_status[ebda_pkg::ST_TYPE_POS +: 2] = req_fetch ? ebda_pkg::TYPE_FETCH :
			(req_write ? ebda_pkg::TYPE_WRITE : ebda_pkg::TYPE_READ);
	end

	always_comb begin
		d = q;
		d.rd_valid = 1'b0;
		d.ab_pre = 1'b0;
		d.ab_dat = 1'b0;
		req_ready = 1'b0;
		abort_ev = 1'b0;
		case (q.st)
			ebda_pkg::ST_IDLE: begin
				if (req_valid) begin
					if (prot_bad || (!req_internal && !in_reg && ((hits == 8'h00) || misal))) begin
						req_ready = 1'b1;
						abort_ev = 1'b1;
						d.ab_pre = req_fetch;
						d.ab_dat = !req_fetch;
					end else if (req_internal || in_reg) begin
						req_ready = 1'b1;
					end else begin
						d.addr = req_addr;
						d.hit = hits;
						d.wide = data_width_field[sel];
						d.bsel = byte_access_type_field[sel];
						d.wr = req_write;
						d.size = req_size;
						d.beats = beats_of(req_size, data_width_field[sel]);
						d.dout = lane_data(req_wdata, req_addr[1:0], req_size,
							data_width_field[sel]);
						d.doe = req_write;
						d.pin_addr = req_addr[23:0];
						d.rd = 32'h00000000;
						d.st = (req_write || !mcr_early_read || q.last_wr) ?
							ebda_pkg::ST_LEAD : ebda_pkg::ST_STROBE;
					end
				end
			end
			ebda_pkg::ST_LEAD: begin
				d.st = ebda_pkg::ST_STROBE;
			end
			ebda_pkg::ST_STROBE: begin
				if (wait_request_n) begin
					if (!q.wr) begin
						if (q.size == ebda_pkg::SIZE_BYTE && q.wide)
							d.rd[8*q.addr[1:0] +: 8] = q.addr[0] ? data_i[15:8] : data_i[7:0];
						else if (q.wide)
							d.rd[16*q.addr[1] +: 16] = data_i;
						else
							d.rd[8*q.addr[1:0] +: 8] = data_i[7:0];
					end
					if (q.beats == 2'h0) begin
						req_ready = 1'b1;
						d.st = ebda_pkg::ST_IDLE;
						d.doe = 1'b0;
						d.rd_valid = !q.wr;
						d.last_wr = q.wr;
					end else begin
						d.beats = q.beats - 2'h1;
						d.addr = q.addr + (q.wide ? 32'h2 : 32'h1);
						d.pin_addr = d.addr[23:0];
						d.dout = lane_data(req_wdata, d.addr[1:0], q.size, q.wide);
						d.st = (q.wr || !mcr_early_read) ? ebda_pkg::ST_LEAD : ebda_pkg::ST_STROBE;
					end
				end
			end
			default: begin
				d.st = ebda_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			q <= '0;
		else if (clk_en)
			q <= d;
	end

	ebda_abort_rec u_abort_rec (
		.sys_clk           (sys_clk),
		.sys_rst           (sys_rst),
		.clk_en            (clk_en),
		.capture           (abort_ev),
		.fault_addr        (req_addr),
		.fault_status      (fault_status),
		.abort_address_reg (abort_address_reg),
		.abort_status_reg  (abort_status_reg)
	);

	assign busy = (q.st != ebda_pkg::ST_IDLE);
	assign strobe = (q.st == ebda_pkg::ST_STROBE);
	assign lane_lo = (q.size != ebda_pkg::SIZE_BYTE) || !q.addr[0];
	assign lane_hi = (q.size != ebda_pkg::SIZE_BYTE) || q.addr[0];

	always_comb begin
		ext_addr = q.pin_addr;
		if (q.wide && q.bsel)
			ext_addr[0] = !(busy && lane_lo);
		for (int k = 0; k < 4; k++) begin
			if (mcr_ale > 3'(k))
				ext_addr[23-k] = busy && q.hit[4+k];
		end
		low_active_selects_n = ~(q.hit[3:0] & {4{busy}});
		read_strobe_n = !(strobe && !q.wr);
		if (!q.wide)
			byte_write_strobes_n = {1'b1, !(strobe && q.wr)};
		else if (q.bsel)
			byte_write_strobes_n = {!(busy && lane_hi), !(strobe && q.wr)};
		else
			byte_write_strobes_n = {!(strobe && q.wr && lane_hi), !(strobe && q.wr && lane_lo)};
	end

	assign data_o = q.dout;
	assign data_oe = q.doe;
	assign rd_data = q.rd;
	assign rd_valid = q.rd_valid;
	assign abort_prefetch = q.ab_pre;
	assign abort_data = q.ab_dat;
endmodule // ebda_top

// >>> verification/ebda_mem_model.sv
// External memory model for the bus front end
`timescale 1ns/100ps
module ebda_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        stall,
	input  wire logic [23:0] ext_addr,
	input  wire logic        read_strobe_n,
	output logic      [15:0] data_i,
	output logic             wait_request_n
);
	logic [7:0] cyc_q = 8'h00;
	logic [1:0] wcnt_q = 2'h0;
	always_ff @(posedge sys_clk) begin
		cyc_q <= cyc_q + 8'h01;
		wcnt_q <= read_strobe_n ? 2'h0 : wcnt_q + 2'h1;
	end
	// Slow answers: two wait cycles per stalled read
	assign wait_request_n = !(stall && !read_strobe_n && wcnt_q < 2'h2);
	// Released bus shows a changing pattern
	assign data_i = read_strobe_n ? {cyc_q, ~cyc_q} : {ext_addr[8:1] ^ 8'h5a, ext_addr[8:1]};
endmodule // ebda_mem_model

// >>> verification/ebda_top_assertions.sv
// Port checks for the bus front end
`timescale 1ns/100ps
module ebda_top_assertions #(
	parameter int NCS = 8
) (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic [31:0] req_addr,
	input wire logic        req_write,
	input wire logic        req_fetch,
	input wire logic [1:0]  req_size,
	input wire logic        req_user,
	input wire logic        req_internal,
	input wire logic        protection_mode_input,
	input wire logic [23:0] ext_addr,
	input wire logic [3:0]  low_active_selects_n,
	input wire logic        read_strobe_n,
	input wire logic [1:0]  byte_write_strobes_n,
	input wire logic        data_oe,
	input wire logic        wait_request_n,
	input wire logic        rd_valid,
	input wire logic        abort_prefetch,
	input wire logic        abort_data,
	input wire logic [31:0] abort_address_reg,
	input wire logic [15:0] abort_status_reg
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic ab;
	assign ab = abort_data | abort_prefetch;
	sequence s_prot_req;
		req_valid && req_ready && protection_mode_input && req_user && !req_internal
			&& req_addr >= ebda_pkg::REG_BASE && req_addr < 32'hffe04000;
	endsequence
	sequence s_stall;
		!wait_request_n && !read_strobe_n;
	endsequence
	a_reset_clears_rec: assert property ($fell(sys_rst) |-> abort_address_reg == 32'h0
		&& abort_status_reg == 16'h0 && low_active_selects_n == 4'hf && !data_oe)
		else $error("records or selects not idle after reset");
	a_abort_addr_rec: assert property (ab |-> $past(req_ready)
		&& abort_address_reg == $past(req_addr)) else $error("abort address not recorded");
	a_record_kept: assert property (!ab |-> $stable(abort_address_reg)
		&& $stable(abort_status_reg)) else $error("abort record changed without abort");
	a_abort_kind: assert property (ab |-> abort_prefetch == $past(req_fetch)
		&& abort_prefetch != abort_data) else $error("wrong abort kind");
	a_status_fields: assert property (ab |-> abort_status_reg[9:8] == $past(req_size)
		&& abort_status_reg[11:10] == ($past(req_fetch) ? 2'h2 : {1'b0, $past(req_write)}))
		else $error("abort status size or type wrong");
	a_internal_quiet: assert property (req_valid && req_internal && req_ready |-> read_strobe_n
		&& byte_write_strobes_n == 2'h3 && low_active_selects_n == 4'hf && !data_oe
		&& $stable(ext_addr[19:0])) else $error("pins active on internal access");
	a_wait_stretch: assert property (s_stall |-> !req_ready ##1 !read_strobe_n)
		else $error("strobe not stretched by wait");
	a_prot_abort: assert property (s_prot_req |=> ab)
		else $error("user access to protected region not aborted");
	a_read_no_drive: assert property (!read_strobe_n |-> !data_oe)
		else $error("data driven during read strobe");
	a_rd_after_read: assert property (rd_valid |-> !ab
		&& $past(req_ready && req_valid && !req_write && !req_internal))
		else $error("read valid without external read");
endmodule // ebda_top_assertions
bind ebda_top ebda_top_assertions #(.NCS(NCS)) u_chk (
	.sys_clk               (sys_clk),
	.sys_rst               (sys_rst),
	.req_valid             (req_valid),
	.req_ready             (req_ready),
	.req_addr              (req_addr),
	.req_write             (req_write),
	.req_fetch             (req_fetch),
	.req_size              (req_size),
	.req_user              (req_user),
	.req_internal          (req_internal),
	.protection_mode_input (protection_mode_input),
	.ext_addr              (ext_addr),
	.low_active_selects_n  (low_active_selects_n),
	.read_strobe_n         (read_strobe_n),
	.byte_write_strobes_n  (byte_write_strobes_n),
	.data_oe               (data_oe),
	.wait_request_n        (wait_request_n),
	.rd_valid              (rd_valid),
	.abort_prefetch        (abort_prefetch),
	.abort_data            (abort_data),
	.abort_address_reg     (abort_address_reg),
	.abort_status_reg      (abort_status_reg)
);

// >>> verification/ebda_top_tb.sv
// Random and corner request test of the bus front end
`timescale 1ns/100ps
module ebda_top_tb;
	logic sys_clk, sys_rst, clk_en, req_valid, req_write, req_fetch, req_user, req_internal;
	logic mcr_early_read, protection_mode_input, stall, req_ready, rd_valid, read_strobe_n;
	logic data_oe, wait_request_n, abort_prefetch, abort_data, wr, fe, user, intl, prot;
	logic [31:0] req_addr, req_wdata, rd_data, abort_address_reg, a, r, seed;
	logic [15:0] abort_status_reg, data_o, data_i;
	logic [7:0] cs_enable, data_width_field, byte_access_type_field;
	logic [7:0][11:0] cs_base;
	logic [7:0][1:0] cs_page;
	logic [23:0] ext_addr;
	logic [3:0] low_active_selects_n;
	logic [2:0] mcr_ale, ale;
	logic [1:0] req_size, byte_write_strobes_n, sz;
	int fail_count, checked;
	ebda_top dut (
		.sys_clk                (sys_clk),
		.sys_rst                (sys_rst),
		.clk_en                 (clk_en),
		.req_valid              (req_valid),
		.req_ready              (req_ready),
		.req_addr               (req_addr),
		.req_write              (req_write),
		.req_fetch              (req_fetch),
		.req_size               (req_size),
		.req_user               (req_user),
		.req_internal           (req_internal),
		.req_wdata              (req_wdata),
		.rd_data                (rd_data),
		.rd_valid               (rd_valid),
		.cs_enable              (cs_enable),
		.cs_base                (cs_base),
		.cs_page                (cs_page),
		.data_width_field       (data_width_field),
		.byte_access_type_field (byte_access_type_field),
		.mcr_ale                (mcr_ale),
		.mcr_early_read         (mcr_early_read),
		.protection_mode_input  (protection_mode_input),
		.ext_addr               (ext_addr),
		.low_active_selects_n   (low_active_selects_n),
		.read_strobe_n          (read_strobe_n),
		.byte_write_strobes_n   (byte_write_strobes_n),
		.data_o                 (data_o),
		.data_oe                (data_oe),
		.data_i                 (data_i),
		.wait_request_n         (wait_request_n),
		.abort_prefetch         (abort_prefetch),
		.abort_data             (abort_data),
		.abort_address_reg      (abort_address_reg),
		.abort_status_reg       (abort_status_reg)
	);
	ebda_mem_model u_mem (
		.sys_clk        (sys_clk),
		.stall          (stall),
		.ext_addr       (ext_addr),
		.read_strobe_n  (read_strobe_n),
		.data_i         (data_i),
		.wait_request_n (wait_request_n)
	);
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	function automatic logic [15:0] hw(input logic [31:0] y);
		return {y[8:1] ^ 8'h5a, y[8:1]};
	endfunction
	// Last write beat on a 16-bit select
	function automatic logic [15:0] lane16(input logic [31:0] w, input logic [31:0] y,
		input logic [1:0] s);
		if (s == 2'h0)
			return {2{w[8*y[1:0] +: 8]}};
		return (s == 2'h2 || y[1]) ? w[31:16] : w[15:0];
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	task automatic end_of_test();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic do_req();
		logic [1:0] sel;
		logic hi, ab, rr, h0, hit, mis;
		logic [15:0] dq;
		logic [31:0] w;
		int n;
		rr = a[31:14] == 18'h3ff80;
		h0 = a[31:20] == 12'h100;
		hit = h0 || (a[31:22] == 10'h080 && ale != 3'h0);
		mis = (sz == 2'h1 && a[0]) || (sz == 2'h2 && a[1:0] != 2'h0);
		ab = rr ? (prot && user) : (!intl && (!hit || mis));
		@(posedge sys_clk);
		{req_valid, req_addr, req_size, req_write, req_fetch} <= {1'b1, a, sz, wr, fe};
		{req_user, req_internal, protection_mode_input, mcr_ale} <= {user, intl, prot, ale};
		{stall, mcr_early_read, byte_access_type_field[0]} <= r[26:24];
		w = $random(seed);
		req_wdata <= w;
		{n, sel, hi} = 0;
		dq = 'x;
		do begin
			@(negedge sys_clk);
			sel |= ~low_active_selects_n[1:0];
			hi |= ext_addr[23];
			if (data_oe)
				dq = data_o;
			n++;
		end while (req_ready !== 1'b1 && n < 40);
		if (n >= 40) begin
			fail_count++;
			end_of_test();
		end
		@(posedge sys_clk);
		req_valid <= 1'b0;
		@(negedge sys_clk);
		chk("abort", ab, abort_data | abort_prefetch);
		chk("rd_valid", !ab && !intl && !rr && !wr, rd_valid);
		if (ab) begin
			chk("prefetch", fe, abort_prefetch);
			chk("abort_addr", a, abort_address_reg);
			chk("abort_stat", {4'h0, fe ? 2'h2 : {1'b0, wr}, sz, 5'h0, rr, mis, !hit && !rr},
				abort_status_reg);
		end else if (!intl && !rr) begin
			if (h0)
				chk("both_sel", 2'h3, sel);
			else
				chk("high_sel", 1'b1, hi);
			if (h0 && !wr && sz != 2'h0)
				chk("rd_data", sz == 2'h2 ? {hw(a + 2), hw(a)} : hw(a),
					sz == 2'h2 ? rd_data : (a[1] ? rd_data[31:16] : rd_data[15:0]));
			if (h0 && wr)
				chk("data_o", lane16(w, a, sz), dq);
		end
		if (intl)
			chk("int_sel", 3'h0, {sel, hi});
	endtask
	initial begin
		{seed, fail_count, checked} = {32'h90b7, 64'h0};
		{sys_rst, clk_en, req_valid, req_write, req_fetch, req_user, req_internal} = 7'h60;
		{mcr_early_read, protection_mode_input, stall, mcr_ale, req_size} = 8'h0;
		{req_addr, req_wdata, cs_base, cs_page} = '0;
		{cs_enable, data_width_field, byte_access_type_field} = {8'h13, 8'h01, 8'h00};
		{cs_base[0], cs_base[1], cs_base[4]} = {12'h100, 12'h100, 12'h200};
		cs_page[4] = 2'h1;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(negedge sys_clk);
		chk("abort_addr", 32'h0, abort_address_reg);
		chk("abort_stat", 16'h0, abort_status_reg);
		for (int i = 0; i < 200; i++) begin
			r = $random(seed);
			a = {r[2:0] == 3'h0 ? 12'h300 : r[2:0] == 3'h1 ? 12'hffe :
				r[3] ? {10'h080, r[5:4]} : 12'h100, 8'h00, r[11:4], r[15:12]};
			sz = r[17:16] == 2'h3 ? 2'h2 : r[17:16];
			if (!r[18] || a[31:20] == 12'hffe)
				a[1:0] = sz == 2'h2 ? 2'h0 : (sz == 2'h1 ? {a[1], 1'b0} : a[1:0]);
			{wr, fe, user, intl, prot, ale} = {r[19], !r[19] && r[20], r[21], r[22] && r[23],
				r[27], r[30:28]};
			case (i)
				0: {a, sz, wr, intl} = {32'h10000100, 2'h2, 2'b00};
				1: {a, sz, intl} = {32'h10000002, 2'h2, 1'b0};
				2: {a, sz, user, prot, intl} = {32'hffe00010, 2'h2, 3'b110};
				3: {a, wr, fe, intl} = {32'h30000000, 3'b010};
				default: ;
			endcase
			do_req();
		end
		end_of_test();
	end
endmodule // ebda_top_tb
